//--- common/ecrh_pkg.sv
// Package for the encoder counter core: register map, option encodings and key-panel states
package ecrh_pkg;
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OFFSET = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_DISPLAY = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [2:0] POINT_MAX = 3'h5;
  localparam logic [2:0] DIGIT_MAX = 3'h5;
  typedef enum logic [1:0] {EDGE_X1 = 2'b00, EDGE_X2 = 2'b01, EDGE_X4 = 2'b10} ecrh_edge_e;
  typedef enum logic [1:0] {IDX_NONE = 2'b00, IDX_RISE = 2'b01, IDX_FALL = 2'b10} ecrh_idx_e;
  typedef enum logic [1:0] {
    UI_OPER = 2'b00, UI_LIST = 2'b01, UI_SHOW = 2'b10, UI_EDIT = 2'b11
  } ecrh_ui_e;
  typedef enum logic [2:0] {
    M_POINT = 3'b000, M_OFFSET = 3'b001, M_KEYRST = 3'b010, M_INDEX = 3'b011,
    M_HOLDEN = 3'b100, M_HOLDTYP = 3'b101, M_SENS = 3'b110, M_EDGES = 3'b111
  } ecrh_menu_e;
  // CTRL layout: edge[1:0] sink[2] index[4:3] keyrst[5] holden[6] holdbg[7] point[10:8]
  typedef struct packed {
    logic [2:0] point;
    logic hold_bg;
    logic hold_en;
    logic key_rst_en;
    ecrh_idx_e idx_mode;
    logic sink_in;
    ecrh_edge_e edge_mode;
  } ecrh_cfg_s;
  localparam int CFG_W = $bits(ecrh_cfg_s);
  localparam ecrh_cfg_s CFG_RESET = '{point: 3'h0, hold_bg: 1'b0, hold_en: 1'b0,
    key_rst_en: 1'b1, idx_mode: IDX_NONE, sink_in: 1'b0, edge_mode: EDGE_X1};
  // Input pin positions in the synchroniser vector
  localparam int NUM_IN = 9;
  localparam int IN_A = 0;
  localparam int IN_B = 1;
  localparam int IN_IDX = 2;
  localparam int IN_HOLD = 3;
  localparam int IN_PROG = 4;
  localparam int IN_RST = 5;
  localparam int IN_UP = 6;
  localparam int IN_DN = 7;
  localparam int IN_LEFT = 8;
endpackage : ecrh_pkg

//--- src/ecrh_counter.sv
// Encoder counter core with offset reset, hold, option keys and APB registers
`timescale 1ns/1ps
`default_nettype none

module ecrh_counter
  import ecrh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic index_in,
  input wire logic hold_in,
  input wire logic program_key,
  input wire logic reset_key,
  input wire logic up_key,
  input wire logic down_key,
  input wire logic left_key,
  output logic [31:0] disp_value,
  output logic [2:0] disp_point,
  output ecrh_ui_e ui_state,
  output ecrh_menu_e menu_item,
  output logic [2:0] edit_digit,
  output logic [31:0] edit_value
);

  logic [NUM_IN-1:0] pins;
  logic [NUM_IN-1:0] s1_reg;
  logic [NUM_IN-1:0] s2_reg;
  logic [NUM_IN-1:0] s3_reg;
  logic [NUM_IN-1:0] filt_reg;
  logic [NUM_IN-1:0] prev_reg;
  logic [NUM_IN-1:0] pol;
  logic [NUM_IN-1:0] pol_prev;
  logic [NUM_IN-1:0] press;
  ecrh_cfg_s cfg_reg;
  logic [31:0] offset_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] disp_reg;
  ecrh_ui_e ui_reg;
  ecrh_menu_e item_reg;
  logic [2:0] digit_reg;
  logic [31:0] edit_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic a, b, pa, pb;
  logic step_up, step_dn;
  logic idx_event, key_event, reset_ev, hold_active, freeze;
  logic prog_enter, store;
  logic apb_acc, apb_wr, mapped;
  logic [31:0] rd_mux;

  assign pins = {left_key, down_key, up_key, reset_key, program_key,
                 hold_in, index_in, phase_b, phase_a};

  // Three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
      prev_reg <= filt_reg;
    end
  end

  // Sinking sensors pull low when active, so their sensor pins are inverted
  assign pol = filt_reg ^ {5'h00, {4{cfg_reg.sink_in}}};
  assign pol_prev = prev_reg ^ {5'h00, {4{cfg_reg.sink_in}}};
  assign press = pol & ~pol_prev;

  assign a = pol[IN_A];
  assign b = pol[IN_B];
  assign pa = pol_prev[IN_A];
  assign pb = pol_prev[IN_B];

  // Quadrature decode: A leading B counts up
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (cfg_reg.edge_mode)
      EDGE_X1: begin
        step_up = a & ~pa & ~b;
        step_dn = ~a & pa & ~b;
      end
      EDGE_X2: begin
        step_up = (a & ~pa & ~b) | (~a & pa & b);
        step_dn = (a & ~pa & b) | (~a & pa & ~b);
      end
      EDGE_X4: begin
        step_up = (a & ~pa & ~b) | (~a & pa & b) | (b & ~pb & a) | (~b & pb & ~a);
        step_dn = (a & ~pa & b) | (~a & pa & ~b) | (b & ~pb & ~a) | (~b & pb & a);
      end
      default: step_up = 1'b0;
    endcase
    if ((a ^ pa) && (b ^ pb)) begin
      step_up = 1'b0;
      step_dn = 1'b0;
    end
  end

  always_comb begin
    case (cfg_reg.idx_mode)
      IDX_RISE: idx_event = pol[IN_IDX] & ~pol_prev[IN_IDX];
      IDX_FALL: idx_event = ~pol[IN_IDX] & pol_prev[IN_IDX];
      default: idx_event = 1'b0;
    endcase
  end

  assign prog_enter = (ui_reg == UI_OPER) & press[IN_RST] & filt_reg[IN_PROG];
  assign key_event = (ui_reg == UI_OPER) & press[IN_RST] & ~filt_reg[IN_PROG]
                     & cfg_reg.key_rst_en;
  assign reset_ev = idx_event | key_event;
  assign hold_active = cfg_reg.hold_en & pol[IN_HOLD];
  assign freeze = hold_active & ~cfg_reg.hold_bg;

  // Reset reloads the offset; a zero offset leaves zero
  always_comb begin
    if (reset_ev) begin
      count_next = offset_reg;
    end else if (freeze) begin
      count_next = count_reg;
    end else if (step_up) begin
      count_next = count_reg + 32'h0000_0001;
    end else if (step_dn) begin
      count_next = count_reg - 32'h0000_0001;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Display tracks the count except while hold is active
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp_reg <= COUNT_RESET;
    end else if (!hold_active) begin
      disp_reg <= count_next;
    end
  end

  function automatic logic [31:0] pow10(input logic [2:0] d);
    case (d)
      3'h0: pow10 = 32'h0000_0001;
      3'h1: pow10 = 32'h0000_000a;
      3'h2: pow10 = 32'h0000_0064;
      3'h3: pow10 = 32'h0000_03e8;
      3'h4: pow10 = 32'h0000_2710;
      default: pow10 = 32'h0001_86a0;
    endcase
  endfunction : pow10

  function automatic logic [31:0] item_max(input ecrh_menu_e m);
    case (m)
      M_POINT: item_max = {29'h0, POINT_MAX};
      M_INDEX: item_max = 32'h0000_0002;
      M_EDGES: item_max = 32'h0000_0002;
      default: item_max = 32'h0000_0001;
    endcase
  endfunction : item_max

  function automatic logic [31:0] item_val(input ecrh_menu_e m, input ecrh_cfg_s c,
                                           input logic [31:0] ofs);
    case (m)
      M_POINT: item_val = {29'h0, c.point};
      M_OFFSET: item_val = ofs;
      M_KEYRST: item_val = {31'h0, c.key_rst_en};
      M_INDEX: item_val = {30'h0, c.idx_mode};
      M_HOLDEN: item_val = {31'h0, c.hold_en};
      M_HOLDTYP: item_val = {31'h0, c.hold_bg};
      M_SENS: item_val = {31'h0, c.sink_in};
      default: item_val = {30'h0, c.edge_mode};
    endcase
  endfunction : item_val

  assign store = (ui_reg == UI_EDIT) & press[IN_PROG];

  // Key panel: list, show, edit, store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ui_reg <= UI_OPER;
      item_reg <= M_POINT;
    end else begin
      case (ui_reg)
        UI_OPER: begin
          if (prog_enter) begin
            ui_reg <= UI_LIST;
            item_reg <= M_POINT;
          end
        end
        UI_LIST: begin
          if (press[IN_RST]) begin
            ui_reg <= UI_OPER;
          end else if (press[IN_PROG]) begin
            ui_reg <= UI_SHOW;
          end else if (press[IN_UP]) begin
            item_reg <= ecrh_menu_e'(item_reg + 3'h1);
          end else if (press[IN_DN]) begin
            item_reg <= ecrh_menu_e'(item_reg - 3'h1);
          end
        end
        UI_SHOW: begin
          if (press[IN_RST]) begin
            ui_reg <= UI_LIST;
          end else if (press[IN_PROG]) begin
            ui_reg <= UI_EDIT;
          end
        end
        UI_EDIT: begin
          if (press[IN_RST] || store) begin
            ui_reg <= UI_LIST;
          end
        end
        default: ui_reg <= UI_OPER;
      endcase
    end
  end

  // Edit buffer and digit position
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edit_reg <= '0;
      digit_reg <= 3'h0;
    end else if (ui_reg == UI_LIST && press[IN_PROG]) begin
      edit_reg <= item_val(item_reg, cfg_reg, offset_reg);
      digit_reg <= 3'h0;
    end else if (ui_reg == UI_EDIT) begin
      if (item_reg == M_OFFSET) begin
        if (press[IN_UP]) begin
          edit_reg <= edit_reg + pow10(digit_reg);
        end else if (press[IN_DN]) begin
          edit_reg <= edit_reg - pow10(digit_reg);
        end else if (press[IN_LEFT]) begin
          digit_reg <= (digit_reg == DIGIT_MAX) ? 3'h0 : digit_reg + 3'h1;
        end
      end else if (press[IN_UP]) begin
        edit_reg <= (edit_reg >= item_max(item_reg)) ? 32'h0 : edit_reg + 32'h1;
      end else if (press[IN_DN]) begin
        edit_reg <= (edit_reg == 32'h0) ? item_max(item_reg) : edit_reg - 32'h1;
      end
    end
  end

  // APB slave: one wait state, error on unmapped address
  assign apb_acc = psel & penable & pready_reg;
  assign apb_wr = apb_acc & pwrite & ~pslverr_reg;
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      OFS_CTRL: rd_mux = {{(32 - CFG_W){1'b0}}, cfg_reg};
      OFS_OFFSET: rd_mux = offset_reg;
      OFS_COUNT: rd_mux = count_reg;
      OFS_DISPLAY: rd_mux = disp_reg;
      OFS_STATUS: rd_mux = {25'h0, item_reg, ui_reg, freeze, hold_active};
      default: begin
        rd_mux = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg) begin
        pslverr_reg <= ~mapped;
        prdata_reg <= pwrite ? 32'h0 : rd_mux;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Option register: bus writes win over the key panel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else if (apb_wr && paddr == OFS_CTRL) begin
      cfg_reg <= ecrh_cfg_s'(pwdata[CFG_W-1:0]);
    end else if (store) begin
      case (item_reg)
        M_POINT: cfg_reg.point <= edit_reg[2:0];
        M_KEYRST: cfg_reg.key_rst_en <= edit_reg[0];
        M_INDEX: cfg_reg.idx_mode <= ecrh_idx_e'(edit_reg[1:0]);
        M_HOLDEN: cfg_reg.hold_en <= edit_reg[0];
        M_HOLDTYP: cfg_reg.hold_bg <= edit_reg[0];
        M_SENS: cfg_reg.sink_in <= edit_reg[0];
        M_EDGES: cfg_reg.edge_mode <= ecrh_edge_e'(edit_reg[1:0]);
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offset_reg <= OFFSET_RESET;
    end else if (apb_wr && paddr == OFS_OFFSET) begin
      offset_reg <= pwdata;
    end else if (store && item_reg == M_OFFSET) begin
      offset_reg <= edit_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign disp_value = disp_reg;
  assign disp_point = cfg_reg.point;
  assign ui_state = ui_reg;
  assign menu_item = item_reg;
  assign edit_digit = digit_reg;
  assign edit_value = edit_reg;

  key_load_a: assert property (@(posedge clk) disable iff (rst)
    key_event |=> count_reg == $past(offset_reg))
    else $error("key reset did not load offset");
  key_off_a: assert property (@(posedge clk) disable iff (rst)
    (ui_reg == UI_OPER) && press[IN_RST] && !cfg_reg.key_rst_en && !idx_event
    && !step_up && !step_dn |=> count_reg == $past(count_reg))
    else $error("disabled reset key changed count");
  idx_load_a: assert property (@(posedge clk) disable iff (rst)
    idx_event |=> count_reg == $past(offset_reg))
    else $error("index edge did not load offset");
  hold_freeze_a: assert property (@(posedge clk) disable iff (rst)
    hold_active |=> disp_reg == $past(disp_reg))
    else $error("display moved during hold");
  hold_off_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_reg.hold_en |=> disp_reg == count_reg)
    else $error("display differs from count with hold disabled");
  bg_count_a: assert property (@(posedge clk) disable iff (rst)
    hold_active && cfg_reg.hold_bg && step_up && !reset_ev
    |=> count_reg == $past(count_reg) + 32'h1)
    else $error("background count lost an edge");
  frz_count_a: assert property (@(posedge clk) disable iff (rst)
    freeze && !reset_ev |=> count_reg == $past(count_reg))
    else $error("count moved during freeze hold");
  dir_down_a: assert property (@(posedge clk) disable iff (rst)
    step_dn && !reset_ev && !freeze |=> count_reg == $past(count_reg) - 32'h1)
    else $error("B leading A did not count down");
  prog_entry_a: assert property (@(posedge clk) disable iff (rst)
    (ui_reg == UI_OPER) && !prog_enter |=> ui_reg == UI_OPER)
    else $error("program mode entered without key chord");
  edit_store_a: assert property (@(posedge clk) disable iff (rst)
    store && item_reg == M_EDGES && !apb_wr
    |=> cfg_reg.edge_mode == $past(edit_reg[1:0]) && ui_reg == UI_LIST)
    else $error("edit value not stored");

endmodule : ecrh_counter
`default_nettype wire

//--- testbench/ecrh_counter_tb_top.sv
// Self-checking bench for the encoder counter core
`timescale 1ns/1ps
`default_nettype none
module ecrh_counter_tb_top
  import ecrh_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic index_in = 1'b0;
  logic hold_in = 1'b0;
  logic sink = 1'b0;
  logic step_up = 1'b0;
  logic step_dn = 1'b0;
  logic [4:0] keys = 5'h00;
  logic phase_a;
  logic phase_b;
  logic [31:0] disp_value;
  logic [2:0] disp_point;
  ecrh_ui_e ui_state;
  ecrh_menu_e menu_item;
  logic [2:0] edit_digit;
  logic [31:0] edit_value;
  logic [31:0] rd;
  logic [31:0] c;
  logic er;
  int failures = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  ecrh_enc_model enc (.clk(clk), .rst(rst), .sink(sink), .step_up(step_up),
    .step_dn(step_dn), .phase_a(phase_a), .phase_b(phase_b));

  ecrh_counter dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a(phase_a), .phase_b(phase_b), .index_in(index_in), .hold_in(hold_in),
    .program_key(keys[0]), .reset_key(keys[1]), .up_key(keys[2]), .down_key(keys[3]),
    .left_key(keys[4]), .disp_value(disp_value), .disp_point(disp_point),
    .ui_state(ui_state), .menu_item(menu_item), .edit_digit(edit_digit),
    .edit_value(edit_value));

  task automatic results;
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  function automatic logic [31:0] cf(input logic [1:0] e, input logic s, input logic [1:0] ix,
      input logic kr, input logic he, input logic hb, input logic [2:0] pt);
    return {21'h0, pt, hb, he, kr, ix, s, e};
  endfunction : cf

  task automatic steps(input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      step_up <= up;
      step_dn <= ~up;
      @(posedge clk);
      step_up <= 1'b0;
      step_dn <= 1'b0;
      tick(5);
    end
    tick(6);
  endtask : steps

  task automatic press(input logic [4:0] k);
    @(posedge clk);
    keys <= k;
    tick(8);
    keys <= 5'h00;
    tick(8);
  endtask : press

  task automatic t_reset;
    rchk(OFS_CTRL, 32'h0000_0020);
    rchk(OFS_OFFSET, 32'h0);
    rchk(OFS_COUNT, 32'h0);
    chk(ui_state, UI_OPER);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_edges;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_CTRL, cf(i[1:0], 1'b0, IDX_NONE, 1'b1, 1'b0, 1'b0, 3'h0));
      apb(1'b0, OFS_COUNT, 32'h0);
      c = rd;
      steps(1'b1, 4);
      rchk(OFS_COUNT, c + (32'h1 << i));
      chk(disp_value, c + (32'h1 << i));
      steps(1'b0, 4);
      rchk(OFS_COUNT, c);
    end
  endtask : t_edges

  task automatic t_sink;
    apb(1'b1, OFS_CTRL, cf(EDGE_X4, 1'b1, IDX_NONE, 1'b1, 1'b0, 1'b0, 3'h0));
    sink <= 1'b1;
    tick(8);
    apb(1'b0, OFS_COUNT, 32'h0);
    c = rd;
    steps(1'b1, 4);
    rchk(OFS_COUNT, c + 32'h4);
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_NONE, 1'b1, 1'b0, 1'b0, 3'h0));
    sink <= 1'b0;
    tick(8);
  endtask : t_sink

  task automatic t_key;
    steps(1'b1, 4);
    press(5'h02);
    rchk(OFS_COUNT, 32'h0);
    chk(disp_value, 32'h0);
    apb(1'b1, OFS_OFFSET, 32'h123);
    press(5'h02);
    rchk(OFS_COUNT, 32'h123);
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_NONE, 1'b0, 1'b0, 1'b0, 3'h0));
    steps(1'b1, 4);
    press(5'h02);
    rchk(OFS_COUNT, 32'h124);
  endtask : t_key

  task automatic t_index;
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_RISE, 1'b1, 1'b0, 1'b0, 3'h0));
    index_in <= 1'b1;
    tick(8);
    rchk(OFS_COUNT, 32'h123);
    steps(1'b1, 4);
    index_in <= 1'b0;
    tick(8);
    rchk(OFS_COUNT, 32'h124);
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_FALL, 1'b1, 1'b0, 1'b0, 3'h0));
    index_in <= 1'b1;
    tick(8);
    rchk(OFS_COUNT, 32'h124);
    index_in <= 1'b0;
    tick(8);
    rchk(OFS_COUNT, 32'h123);
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_NONE, 1'b1, 1'b0, 1'b0, 3'h0));
    steps(1'b1, 4);
    index_in <= 1'b1;
    tick(8);
    index_in <= 1'b0;
    tick(8);
    rchk(OFS_COUNT, 32'h124);
  endtask : t_index

  task automatic t_hold;
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_NONE, 1'b1, 1'b1, 1'b1, 3'h0));
    apb(1'b0, OFS_COUNT, 32'h0);
    c = rd;
    hold_in <= 1'b1;
    tick(8);
    steps(1'b1, 4);
    chk(disp_value, c);
    rchk(OFS_COUNT, c + 32'h1);
    rchk(OFS_STATUS, 32'h0000_0001);
    hold_in <= 1'b0;
    tick(8);
    chk(disp_value, c + 32'h1);
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_NONE, 1'b1, 1'b1, 1'b0, 3'h0));
    hold_in <= 1'b1;
    tick(8);
    steps(1'b1, 4);
    rchk(OFS_COUNT, c + 32'h1);
    rchk(OFS_STATUS, 32'h0000_0003);
    hold_in <= 1'b0;
    tick(8);
    steps(1'b1, 4);
    chk(disp_value, c + 32'h2);
    apb(1'b1, OFS_CTRL, cf(EDGE_X1, 1'b0, IDX_NONE, 1'b1, 1'b0, 1'b0, 3'h3));
    hold_in <= 1'b1;
    tick(8);
    steps(1'b1, 4);
    chk(disp_value, c + 32'h3);
    chk(disp_point, 3'h3);
    hold_in <= 1'b0;
  endtask : t_hold

  task automatic t_menu;
    press(5'h01);
    chk(ui_state, UI_OPER);
    keys <= 5'h01;
    tick(8);
    press(5'h03);
    chk(ui_state, UI_LIST);
    chk(menu_item, M_POINT);
    press(5'h04);
    chk(menu_item, M_OFFSET);
    press(5'h01);
    chk(ui_state, UI_SHOW);
    chk(edit_value, 32'h123);
    press(5'h01);
    chk(ui_state, UI_EDIT);
    chk(edit_digit, 3'h0);
    press(5'h04);
    chk(edit_value, 32'h124);
    press(5'h10);
    chk(edit_digit, 3'h1);
    press(5'h04);
    chk(edit_value, 32'h12e);
    press(5'h01);
    chk(ui_state, UI_LIST);
    rchk(OFS_OFFSET, 32'h12e);
    press(5'h08);
    press(5'h08);
    chk(menu_item, M_EDGES);
    press(5'h01);
    chk(edit_value, EDGE_X1);
    press(5'h01);
    press(5'h08);
    chk(edit_value, EDGE_X4);
    press(5'h01);
    chk(ui_state, UI_LIST);
    rchk(OFS_CTRL, 32'h0000_0322);
    press(5'h02);
    chk(ui_state, UI_OPER);
  endtask : t_menu

  initial begin
    tick(5);
    rst <= 1'b0;
    t_reset;
    t_edges;
    t_sink;
    t_key;
    t_index;
    t_hold;
    t_menu;
    results();
  end

  initial begin
    tick(30000);
    failures++;
    results();
  end
endmodule : ecrh_counter_tb_top
`default_nettype wire

//--- testbench/ecrh_enc_model.sv
// Encoder model: quadrature phases stepped on request, outputs inverted for sinking sensors
`timescale 1ns/1ps
`default_nettype none
module ecrh_enc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sink,
  input wire logic step_up,
  input wire logic step_dn,
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg <= 2'h0;
    end else if (step_up) begin
      pos_reg <= pos_reg + 2'h1;
    end else if (step_dn) begin
      pos_reg <= pos_reg - 2'h1;
    end
  end
  // Order 00,10,11,01 puts A ahead of B when stepping up
  assign phase_a = sink ^ (pos_reg == 2'h1 || pos_reg == 2'h2);
  assign phase_b = sink ^ pos_reg[1];
endmodule : ecrh_enc_model
`default_nettype wire
